// File: ata_pkg.sv
package ata_pkg;

  localparam int unsigned ATA_ADDR_W = 64;
  localparam int unsigned ATA_MT_W = 8;
  localparam int unsigned ATA_SIZE_W = 6;

  // Attribute carried in unused upper bits of a Translated Address
  localparam int unsigned ATA_ENC_MT_LSB = 52;
  localparam int unsigned ATA_ENC_SH_LSB = 60;
  localparam int unsigned ATA_PA_W = 52;

  localparam logic [1:0] ATA_MODE_OFF = 2'h0;
  localparam logic [1:0] ATA_MODE_DIRECT = 2'h1;
  localparam logic [1:0] ATA_MODE_SPLIT = 2'h2;
  localparam logic [2:0] ATA_CFG_NESTED = 3'h7;
  localparam int unsigned ATA_CFG_S1_BIT = 0;
  localparam int unsigned ATA_CFG_S2_BIT = 1;

  // Fixed upstream attribute: Normal WB, inner shareable
  localparam logic [7:0] ATA_FIXED_IN_MT = 8'hFF;
  localparam logic [1:0] ATA_FIXED_IN_SH = 2'h3;
  localparam logic [7:0] ATA_NOSNOOP_MT = 8'h44;
  localparam logic [3:0] ATA_NC_NIBBLE = 4'h4;
  localparam logic [3:0] ATA_DEV_NIBBLE = 4'h0;
  localparam logic [1:0] ATA_SH_NSH = 2'h0;
  localparam logic [1:0] ATA_SH_OSH = 2'h2;
  localparam logic [1:0] ATA_SH_ISH = 2'h3;

  localparam logic [1:0] ATA_OVR_DATA = 2'h2;
  localparam logic [1:0] ATA_OVR_SET = 2'h3;

  typedef enum logic [1:0] {
    ATA_EVT_NONE      = 2'h0,
    ATA_EVT_S2_FAULT  = 2'h1,
    ATA_EVT_S2_PERM   = 2'h2,
    ATA_EVT_ATS_BLOCK = 2'h3
  } ata_evt_t;

  typedef struct packed {
    logic [7:0] mt;
    logic [1:0] sh;
  } ata_attr_t;

  localparam ata_attr_t ATA_ATTR_RESET = '{mt: 8'h00, sh: 2'h0};

  function automatic logic ata_is_device(input logic [7:0] mt);
    return mt[7:4] == ATA_DEV_NIBBLE;
  endfunction

  function automatic logic [3:0] ata_min4(input logic [3:0] a, input logic [3:0] b);
    return (a < b) ? a : b;
  endfunction

  // Stage combine: device wins, else weaker cacheability, outer wins shareability
  function automatic ata_attr_t ata_combine(input ata_attr_t a, input ata_attr_t b);
    ata_attr_t r;
    if (ata_is_device(a.mt) || ata_is_device(b.mt)) begin
      r.mt = (a.mt < b.mt) ? a.mt : b.mt;
    end else begin
      r.mt = {ata_min4(a.mt[7:4], b.mt[7:4]), ata_min4(a.mt[3:0], b.mt[3:0])};
    end
    if (a.sh == ATA_SH_OSH || b.sh == ATA_SH_OSH) begin
      r.sh = ATA_SH_OSH;
    end else if (a.sh == ATA_SH_ISH || b.sh == ATA_SH_ISH) begin
      r.sh = ATA_SH_ISH;
    end else begin
      r.sh = ATA_SH_NSH;
    end
    return r;
  endfunction

  function automatic logic ata_ovr(input logic [1:0] cfg, input logic in_val);
    return (cfg == ATA_OVR_SET) ? 1'b1 : ((cfg == ATA_OVR_DATA) ? 1'b0 : in_val);
  endfunction

endpackage

// File: ata_translated_attr.sv
// Function
// - No_snoop turns final Normal cacheable output into Normal iNC-oNC-OSH.
// - Device-type final attributes pass the No_snoop downgrade unchanged.
// - No_snoop downgrade applies after stage 2 forced-writeback handling.
// - Every Translation Completion carries N equal to zero.
// - Translated attribute derivation is independent of later No_snoop downgrade.
// - Untranslated input attribute is fixed; output from overrides and descriptors.
// - Translated transactions skip translation except stage 2 in mode 0b10; attributes adjusted per page if supported.
// - Split-stage needs mode 0b10, check enable 1, stage config 0b111.
// - Split-stage completion returns stage 1 intermediate address, not physical.
// - Split-stage encoded attribute yields stage1+stage2 combined result after stage 2.
// - Split-stage flag updates at request walk or at later Translated transaction.
// - Completion permissions combine both stages, limited to those requested.
// - Completion size at most the smaller of both stage sizes.
// - Mode 0b01 Translated goes out as physical with encoded or fixed attribute.
// - Mode 0b10 Translated address goes through stage 2; faults raise events.
// - Mode 0b10 encoded or fixed attribute combines with stage 2 attribute.
// - Instruction and privilege overrides apply before stage 2 for mode 0b10.
// - Privilege affects stage 2 permission only with split-exec capability set.
// - With checking on, Translated traffic is checked against the stream entry.
// - Translated attributes are page-derived or fixed, chosen by a strap.
// - Stage config bit 0 enables stage 1, bit 1 enables stage 2.
`timescale 1ns/1ps
module ata_translated_attr
  import ata_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  // Global configuration
  input  wire logic                  NO_SNOOP_SUPPORT,
  input  wire logic                  ATS_ATTR_SUPPORT,
  input  wire logic                  TRANSLATED_CHECK_ENABLE,
  input  wire logic                  SPLIT_EXEC_PERM_CAPABILITY,
  input  wire logic                  HTTU_AT_REQUEST,
  // Per-stream configuration
  input  wire logic [1:0]            ATS_MODE_FIELD,
  input  wire logic [2:0]            STAGE_CONFIG,
  input  wire logic [1:0]            INSTRUCTION_OVERRIDE,
  input  wire logic [1:0]            PRIVILEGE_OVERRIDE,
  input  wire logic                  MEMTYPE_OVERRIDE_EN,
  input  wire logic [7:0]            MEMTYPE_OVERRIDE,
  input  wire logic                  SHAREABILITY_OVERRIDE_EN,
  input  wire logic [1:0]            SHAREABILITY_OVERRIDE,
  input  wire logic                  STAGE2_FORCED_WRITEBACK,
  // Incoming transaction
  input  wire logic                  TXN_VALID,
  input  wire logic                  TXN_TRANSLATED,
  input  wire logic [63:0]           TXN_ADDR,
  input  wire logic                  TXN_WRITE,
  input  wire logic                  TXN_INST,
  input  wire logic                  TXN_PRIV,
  input  wire logic                  TXN_NO_SNOOP,
  // Incoming Translation Request
  input  wire logic                  TREQ_VALID,
  input  wire logic                  TREQ_NO_WRITE,
  input  wire logic                  TREQ_EXEC,
  input  wire logic                  TREQ_PRIV,
  output logic                       TREQ_READY,
  // Walk results for the presented address
  input  wire logic [7:0]            S1_MT,
  input  wire logic [1:0]            S1_SH,
  input  wire logic [63:0]           S1_OUT_ADDR,
  input  wire logic [2:0]            S1_PERM,
  input  wire logic [5:0]            S1_SIZE,
  input  wire logic [7:0]            S2_MT,
  input  wire logic [1:0]            S2_SH,
  input  wire logic [63:0]           S2_OUT_ADDR,
  input  wire logic [3:0]            S2_PERM,
  input  wire logic [5:0]            S2_SIZE,
  input  wire logic                  S2_FAULT,
  // Outgoing transaction
  output logic                       OUT_VALID,
  output logic [63:0]                OUT_ADDR,
  output logic [7:0]                 OUT_MT,
  output logic [1:0]                 OUT_SH,
  output logic                       OUT_WRITE,
  output logic                       OUT_INST,
  output logic                       OUT_PRIV,
  // Translation Completion
  output logic                       CPL_VALID,
  output logic [63:0]                CPL_ADDR,
  output logic                       CPL_R,
  output logic                       CPL_W,
  output logic                       CPL_X,
  output logic                       CPL_N,
  output logic [5:0]                 CPL_SIZE,
  // Events and flag updates
  output logic                       EVT_VALID,
  output ata_evt_t                   EVT_CODE,
  output logic                       HTTU_DIRTY
);

  localparam ata_attr_t FIXED_IN = '{mt: ATA_FIXED_IN_MT, sh: ATA_FIXED_IN_SH};

  ata_attr_t  in_attr;
  ata_attr_t  s1_attr;
  ata_attr_t  s2_attr;
  ata_attr_t  enc_attr;
  ata_attr_t  pre_attr;
  ata_attr_t  s2_in;
  ata_attr_t  s2_res;
  ata_attr_t  final_attr;
  ata_attr_t  full_attr;
  logic       s1_en;
  logic       s2_en;
  logic       split_act;
  logic       inst_eff;
  logic       priv_eff;
  logic       s2_perm_ok;
  logic       txn_go;

  logic        out_valid_d, out_valid_q;
  logic [63:0] out_addr_d,  out_addr_q;
  ata_attr_t   out_attr_d,  out_attr_q;
  logic        out_write_d, out_write_q;
  logic        out_inst_d,  out_inst_q;
  logic        out_priv_d,  out_priv_q;
  logic        cpl_valid_d, cpl_valid_q;
  logic [63:0] cpl_addr_d,  cpl_addr_q;
  logic [2:0]  cpl_perm_d,  cpl_perm_q;
  logic [5:0]  cpl_size_d,  cpl_size_q;
  logic        evt_valid_d, evt_valid_q;
  ata_evt_t    evt_code_d,  evt_code_q;
  logic        dirty_d,     dirty_q;
  logic        dirty_q_next_set;

  function automatic logic [63:0] ata_encode(input logic [63:0] a, input ata_attr_t at);
    logic [63:0] r;
    r = a;
    r[ATA_ENC_MT_LSB +: ATA_MT_W] = at.mt;
    r[ATA_ENC_SH_LSB +: 2] = at.sh;
    return r;
  endfunction

  // Stage 2 result, with forced writeback taking the stage 2 attribute
  function automatic ata_attr_t ata_stage2(input ata_attr_t in, input ata_attr_t s2, input logic fwb);
    return fwb ? s2 : ata_combine(in, s2);
  endfunction

  assign TREQ_READY = !TXN_VALID;
  assign txn_go     = TXN_VALID;

  always_comb begin
    s1_en     = STAGE_CONFIG[ATA_CFG_S1_BIT];
    s2_en     = STAGE_CONFIG[ATA_CFG_S2_BIT];
    split_act = (ATS_MODE_FIELD == ATA_MODE_SPLIT) && TRANSLATED_CHECK_ENABLE
                && (STAGE_CONFIG == ATA_CFG_NESTED);
    s1_attr   = '{mt: S1_MT, sh: S1_SH};
    s2_attr   = '{mt: S2_MT, sh: S2_SH};
    // Untranslated: fixed input replaced by stream overrides
    in_attr    = FIXED_IN;
    if (MEMTYPE_OVERRIDE_EN) begin
      in_attr.mt = MEMTYPE_OVERRIDE;
    end
    if (SHAREABILITY_OVERRIDE_EN) begin
      in_attr.sh = SHAREABILITY_OVERRIDE;
    end
    // Page-derived encoding only when the strap allows it, else fixed
    enc_attr = ATS_ATTR_SUPPORT
               ? ata_attr_t'{mt: TXN_ADDR[ATA_ENC_MT_LSB +: ATA_MT_W], sh: TXN_ADDR[ATA_ENC_SH_LSB +: 2]}
               : FIXED_IN;
    pre_attr  = s1_en ? s1_attr : in_attr;
    full_attr = s2_en ? ata_stage2(pre_attr, s2_attr, STAGE2_FORCED_WRITEBACK) : pre_attr;
  end

  // Stage 2 input and permission check for translated traffic
  always_comb begin
    s2_in    = enc_attr;
    s2_res   = ata_stage2(s2_in, s2_attr, STAGE2_FORCED_WRITEBACK);
    inst_eff = ata_ovr(INSTRUCTION_OVERRIDE, TXN_INST);
    priv_eff = ata_ovr(PRIVILEGE_OVERRIDE, TXN_PRIV);
    if (TXN_WRITE) begin
      s2_perm_ok = S2_PERM[1];
    end else if (inst_eff) begin
      // Privileged execute column only exists with the split capability
      s2_perm_ok = (SPLIT_EXEC_PERM_CAPABILITY && priv_eff) ? S2_PERM[3] : S2_PERM[2];
    end else begin
      s2_perm_ok = S2_PERM[0];
    end
  end

  // Transaction path
  always_comb begin
    out_valid_d = 1'b0;
    out_addr_d  = out_addr_q;
    out_attr_d  = out_attr_q;
    out_write_d = out_write_q;
    out_inst_d  = out_inst_q;
    out_priv_d  = out_priv_q;
    evt_valid_d = 1'b0;
    evt_code_d  = evt_code_q;
    final_attr  = full_attr;
    dirty_d     = 1'b0;
    if (txn_go) begin
      out_valid_d = 1'b1;
      out_write_d = TXN_WRITE;
      out_inst_d  = TXN_INST;
      out_priv_d  = TXN_PRIV;
      out_addr_d  = S2_OUT_ADDR;
      if (!TXN_TRANSLATED) begin
        out_addr_d = s2_en ? S2_OUT_ADDR : (s1_en ? S1_OUT_ADDR : TXN_ADDR);
        out_inst_d = ata_ovr(INSTRUCTION_OVERRIDE, TXN_INST);
        out_priv_d = ata_ovr(PRIVILEGE_OVERRIDE, TXN_PRIV);
        final_attr = full_attr;
        if (s2_en && S2_FAULT) begin
          out_valid_d = 1'b0;
          evt_valid_d = 1'b1;
          evt_code_d  = ATA_EVT_S2_FAULT;
        end
      end else if (!TRANSLATED_CHECK_ENABLE || ATS_MODE_FIELD == ATA_MODE_DIRECT) begin
        out_addr_d = {{(ATA_ADDR_W - ATA_PA_W){1'b0}}, TXN_ADDR[ATA_PA_W-1:0]};
        final_attr = enc_attr;
      end else if (ATS_MODE_FIELD == ATA_MODE_SPLIT) begin
        out_inst_d = inst_eff;
        out_priv_d = priv_eff;
        final_attr = s2_res;
        if (S2_FAULT || !s2_perm_ok) begin
          out_valid_d = 1'b0;
          evt_valid_d = 1'b1;
          evt_code_d  = S2_FAULT ? ATA_EVT_S2_FAULT : ATA_EVT_S2_PERM;
        end else if (TXN_WRITE && !HTTU_AT_REQUEST) begin
          dirty_d = 1'b1;
        end
      end else begin
        // Checked stream with ATS disabled refuses translated traffic
        out_valid_d = 1'b0;
        evt_valid_d = 1'b1;
        evt_code_d  = ATA_EVT_ATS_BLOCK;
      end
      // Downgrade last, after forced writeback and attribute derivation
      if (NO_SNOOP_SUPPORT && TXN_NO_SNOOP && !ata_is_device(final_attr.mt)) begin
        final_attr = '{mt: ATA_NOSNOOP_MT, sh: ATA_SH_OSH};
      end
      out_attr_d = final_attr;
    end
  end

  // Translation Completion path
  always_comb begin
    cpl_valid_d = 1'b0;
    cpl_addr_d  = cpl_addr_q;
    cpl_perm_d  = cpl_perm_q;
    cpl_size_d  = cpl_size_q;
    if (TREQ_VALID && !txn_go) begin
      cpl_valid_d   = 1'b1;
      cpl_perm_d[0] = S1_PERM[0] && (!s2_en || S2_PERM[0]);
      cpl_perm_d[1] = !TREQ_NO_WRITE && S1_PERM[1] && (!s2_en || S2_PERM[1]);
      cpl_perm_d[2] = TREQ_EXEC && S1_PERM[2] && (!s2_en || S2_PERM[2]);
      if (!(s1_en && s2_en)) begin
        cpl_size_d = s2_en ? S2_SIZE : S1_SIZE;
      end else begin
        cpl_size_d = (S1_SIZE < S2_SIZE) ? S1_SIZE : S2_SIZE;
      end
      if (split_act) begin
        // Encoded stage 1 attribute is combined again at stage 2 later
        cpl_addr_d = ata_encode(S1_OUT_ADDR, s1_attr);
      end else begin
        cpl_addr_d = ata_encode(s2_en ? S2_OUT_ADDR : S1_OUT_ADDR, full_attr);
      end
      if (s2_en && S2_FAULT) begin
        cpl_perm_d = 3'h0;
      end
    end
  end

  always_comb begin
    if (TREQ_VALID && !txn_go && split_act && HTTU_AT_REQUEST && cpl_perm_d[1]) begin
      dirty_q_next_set = 1'b1;
    end else begin
      dirty_q_next_set = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      out_valid_q <= 1'b0;
      out_addr_q  <= '0;
      out_attr_q  <= ATA_ATTR_RESET;
      out_write_q <= 1'b0;
      out_inst_q  <= 1'b0;
      out_priv_q  <= 1'b0;
      cpl_valid_q <= 1'b0;
      cpl_addr_q  <= '0;
      cpl_perm_q  <= 3'h0;
      cpl_size_q  <= '0;
      evt_valid_q <= 1'b0;
      evt_code_q  <= ATA_EVT_NONE;
      dirty_q     <= 1'b0;
    end else begin
      out_valid_q <= out_valid_d;
      out_addr_q  <= out_addr_d;
      out_attr_q  <= out_attr_d;
      out_write_q <= out_write_d;
      out_inst_q  <= out_inst_d;
      out_priv_q  <= out_priv_d;
      cpl_valid_q <= cpl_valid_d;
      cpl_addr_q  <= cpl_addr_d;
      cpl_perm_q  <= cpl_perm_d;
      cpl_size_q  <= cpl_size_d;
      evt_valid_q <= evt_valid_d;
      evt_code_q  <= evt_code_d;
      dirty_q     <= dirty_d || dirty_q_next_set;
    end
  end

  assign OUT_VALID  = out_valid_q;
  assign OUT_ADDR   = out_addr_q;
  assign OUT_MT     = out_attr_q.mt;
  assign OUT_SH     = out_attr_q.sh;
  assign OUT_WRITE  = out_write_q;
  assign OUT_INST   = out_inst_q;
  assign OUT_PRIV   = out_priv_q;
  assign CPL_VALID  = cpl_valid_q;
  assign CPL_ADDR   = cpl_addr_q;
  assign CPL_R      = cpl_perm_q[0];
  assign CPL_W      = cpl_perm_q[1];
  assign CPL_X      = cpl_perm_q[2];
  assign CPL_N      = 1'b0;
  assign CPL_SIZE   = cpl_size_q;
  assign EVT_VALID  = evt_valid_q;
  assign EVT_CODE   = evt_code_q;
  assign HTTU_DIRTY = dirty_q;

endmodule

// File: ata_translated_attr_checker.sv
`timescale 1ns/1ps
module ata_translated_attr_checker
  import ata_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Requests and configuration
  input wire logic        NO_SNOOP_SUPPORT,
  input wire logic        TRANSLATED_CHECK_ENABLE,
  input wire logic [1:0]  ATS_MODE_FIELD,
  input wire logic [2:0]  STAGE_CONFIG,
  input wire logic        TXN_VALID,
  input wire logic        TXN_TRANSLATED,
  input wire logic [63:0] TXN_ADDR,
  input wire logic        TXN_NO_SNOOP,
  input wire logic        TREQ_VALID,
  input wire logic [5:0]  S1_SIZE,
  input wire logic [5:0]  S2_SIZE,
  // Answers
  input wire logic        OUT_VALID,
  input wire logic [63:0] OUT_ADDR,
  input wire logic [7:0]  OUT_MT,
  input wire logic [1:0]  OUT_SH,
  input wire logic        CPL_VALID,
  input wire logic        CPL_N,
  input wire logic [5:0]  CPL_SIZE,
  input wire logic        EVT_VALID,
  input wire ata_evt_t    EVT_CODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  AST_N_ZERO: assert property (CPL_N == 1'b0)
    else $error("completion N bit set");
  AST_ONE_ANSWER: assert property (TXN_VALID |=> OUT_VALID != EVT_VALID)
    else $error("transaction not answered exactly once");
  AST_CPL_CAUSE: assert property (CPL_VALID |-> $past(TREQ_VALID && !TXN_VALID))
    else $error("completion without accepted request");
  AST_NOSNOOP: assert property (OUT_VALID && $past(NO_SNOOP_SUPPORT && TXN_NO_SNOOP) && OUT_MT[7:4] != 4'h0
    |-> OUT_MT == ATA_NOSNOOP_MT && OUT_SH == ATA_SH_OSH)
    else $error("no snoop output not downgraded");
  AST_BLOCKED: assert property (TXN_VALID && TXN_TRANSLATED && TRANSLATED_CHECK_ENABLE
    && ATS_MODE_FIELD == ATA_MODE_OFF |=> EVT_VALID && EVT_CODE == ATA_EVT_ATS_BLOCK)
    else $error("translated access in mode off not blocked");
  AST_DIRECT_ADDR: assert property (TXN_VALID && TXN_TRANSLATED && ATS_MODE_FIELD == ATA_MODE_DIRECT
    |=> OUT_VALID && OUT_ADDR[51:0] == $past(TXN_ADDR[51:0]))
    else $error("direct translated address altered");
  AST_UNCHECKED: assert property (TXN_VALID && TXN_TRANSLATED && !TRANSLATED_CHECK_ENABLE
    |=> OUT_VALID && !EVT_VALID)
    else $error("unchecked translated access refused");
  AST_SIZE: assert property (CPL_VALID && $past(STAGE_CONFIG) == ATA_CFG_NESTED
    |-> CPL_SIZE <= $past(S1_SIZE) && CPL_SIZE <= $past(S2_SIZE))
    else $error("completion size too large");
  CV_CPL: cover property (CPL_VALID);
  CV_BLOCK: cover property (EVT_VALID && EVT_CODE == ATA_EVT_ATS_BLOCK);
  CV_NOSNOOP: cover property (OUT_VALID && OUT_MT == ATA_NOSNOOP_MT);
endmodule
bind ata_translated_attr ata_translated_attr_checker ata_translated_attr_checker_inst (.*);

// File: ata_rc_endpoint.sv
`timescale 1ns/1ps
module ata_rc_endpoint (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Completion from the unit
  input  wire logic        cpl_valid,
  input  wire logic [63:0] cpl_addr,
  // Cached translation, page offset cleared
  output logic      [63:0] atc_addr
);
  logic [51:0] atc_d;
  logic [51:0] atc_q;
  // Bits 63:12 kept whole, so encoded attributes ride back untouched
  always_comb begin
    atc_d = cpl_valid ? cpl_addr[63:12] : atc_q;
  end
  always_ff @(posedge clk) begin
    atc_q <= resetn ? atc_d : 52'h0;
  end
  assign atc_addr = {atc_q, 12'h000};
endmodule

// File: ata_translated_attr_test.sv
`timescale 1ns/1ps
module ata_translated_attr_test;
  import ata_pkg::*;
  logic CLK, RESETN, NO_SNOOP_SUPPORT, ATS_ATTR_SUPPORT, TRANSLATED_CHECK_ENABLE, SPLIT_EXEC_PERM_CAPABILITY;
  logic HTTU_AT_REQUEST, MEMTYPE_OVERRIDE_EN, SHAREABILITY_OVERRIDE_EN, STAGE2_FORCED_WRITEBACK, TXN_VALID;
  logic TXN_TRANSLATED, TXN_WRITE, TXN_INST, TXN_PRIV, TXN_NO_SNOOP, TREQ_VALID, TREQ_NO_WRITE, TREQ_EXEC;
  logic TREQ_PRIV, TREQ_READY, S2_FAULT, OUT_VALID, OUT_WRITE, OUT_INST, OUT_PRIV, CPL_VALID, CPL_R, CPL_W;
  logic CPL_X, CPL_N, EVT_VALID, HTTU_DIRTY;
  logic [1:0]  ATS_MODE_FIELD, INSTRUCTION_OVERRIDE, PRIVILEGE_OVERRIDE, SHAREABILITY_OVERRIDE, S1_SH, S2_SH, OUT_SH;
  logic [2:0]  STAGE_CONFIG, S1_PERM;
  logic [3:0]  S2_PERM;
  logic [5:0]  S1_SIZE, S2_SIZE, CPL_SIZE;
  logic [7:0]  MEMTYPE_OVERRIDE, S1_MT, S2_MT, OUT_MT;
  logic [63:0] TXN_ADDR, S1_OUT_ADDR, S2_OUT_ADDR, OUT_ADDR, CPL_ADDR, atc_addr;
  ata_evt_t    EVT_CODE;
  int          err_count, checks_done;
  logic [31:0] seed;
  logic [7:0]  mts [8] = '{8'hFF, 8'hEE, 8'hAA, 8'hBB, 8'h00, 8'h04, 8'h08, 8'h0C};
  logic [1:0]  shs [4] = '{2'h0, 2'h2, 2'h3, 2'h3};
  ata_translated_attr ata_translated_attr_inst (.*);
  ata_rc_endpoint ata_rc_endpoint_inst (.clk(CLK), .resetn(RESETN), .cpl_valid(CPL_VALID), .cpl_addr(CPL_ADDR),
    .atc_addr(atc_addr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] mn(logic [3:0] a, logic [3:0] b);
    return (a < b) ? a : b;
  endfunction
  // Attributes packed as {memtype, shareability}
  function automatic logic [9:0] comb(logic [9:0] a, logic [9:0] b);
    logic dev;
    dev = a[9:6] == 4'h0 || b[9:6] == 4'h0;
    return {dev ? ((a[9:2] < b[9:2]) ? a[9:2] : b[9:2]) : {mn(a[9:6], b[9:6]), mn(a[5:2], b[5:2])},
      (a[1:0] == 2'h2 || b[1:0] == 2'h2) ? 2'h2 : (a[1:0] == 2'h3 || b[1:0] == 2'h3) ? 2'h3 : 2'h0};
  endfunction
  function automatic logic [9:0] nsd(logic [9:0] a);
    return (NO_SNOOP_SUPPORT && TXN_NO_SNOOP && a[9:6] != 4'h0) ? {ATA_NOSNOOP_MT, ATA_SH_OSH} : a;
  endfunction
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Kinds: 0 untranslated, 1 direct, 2 split, 3 blocked, 4 request, 5 idle, 6 exec override
  task automatic op(int k);
    logic [31:0] r, q;
    logic [9:0]  ei, ea, s2;
    logic        ok, iv, pv, sp, ew;
    r = rnd();
    q = rnd();
    @(negedge CLK);
    {NO_SNOOP_SUPPORT, ATS_ATTR_SUPPORT, STAGE2_FORCED_WRITEBACK, HTTU_AT_REQUEST, TXN_NO_SNOOP} = r[4:0];
    {TXN_INST, TREQ_NO_WRITE, TREQ_EXEC, S1_PERM, S1_SIZE, S2_SIZE, TXN_PRIV} = r[23:5];
    {MEMTYPE_OVERRIDE_EN, SHAREABILITY_OVERRIDE_EN} = (k == 0) ? r[29:28] : 2'h0;
    SPLIT_EXEC_PERM_CAPABILITY = k == 6 || q[20];
    TXN_WRITE = k != 6 && q[21];
    S2_PERM = (k == 6) ? 4'hB : q[25:22];
    S2_FAULT = r[31:30] == 2'h0 && k != 6;
    {MEMTYPE_OVERRIDE, S1_MT, S2_MT} = {mts[q[2:0]], mts[q[5:3]], mts[q[8:6]]};
    {SHAREABILITY_OVERRIDE, S1_SH, S2_SH} = {shs[q[10:9]], shs[q[12:11]], shs[q[14:13]]};
    TXN_ADDR = (k == 2) ? {atc_addr[63:12], q[11:0]} : {2'h0, shs[q[16:15]], mts[q[19:17]], 20'h0, rnd()};
    S1_OUT_ADDR = {12'h000, q[31:12], rnd()};
    S2_OUT_ADDR = {12'h000, r[19:0], rnd()};
    TXN_VALID = k < 4 || k == 6;
    TXN_TRANSLATED = k != 0;
    TREQ_VALID = k == 4 || (k == 0 && q[26]);
    TRANSLATED_CHECK_ENABLE = k != 1 || q[27];
    // Split mode only ever set with checking on
    ATS_MODE_FIELD = (k == 3) ? ATA_MODE_OFF : (k == 2 || k == 6 || (k == 4 && q[28])) ? ATA_MODE_SPLIT
      : (k == 1 && !TRANSLATED_CHECK_ENABLE) ? {1'b0, q[29]} : ATA_MODE_DIRECT;
    STAGE_CONFIG = (k == 0) ? 3'h6 : ATA_CFG_NESTED;
    INSTRUCTION_OVERRIDE = (k == 6) ? ATA_OVR_SET : {q[30], 1'b0};
    PRIVILEGE_OVERRIDE = (k == 6) ? {1'b1, q[31]} : r[31:30];
    ei = (k == 0) ? {MEMTYPE_OVERRIDE_EN ? MEMTYPE_OVERRIDE : ATA_FIXED_IN_MT,
      SHAREABILITY_OVERRIDE_EN ? SHAREABILITY_OVERRIDE : ATA_FIXED_IN_SH}
      : ATS_ATTR_SUPPORT ? {TXN_ADDR[59:52], TXN_ADDR[61:60]} : {ATA_FIXED_IN_MT, ATA_FIXED_IN_SH};
    s2 = {S2_MT, S2_SH};
    ea = (k == 1) ? ei : STAGE2_FORCED_WRITEBACK ? s2 : comb(ei, s2);
    iv = INSTRUCTION_OVERRIDE[1] ? INSTRUCTION_OVERRIDE[0] : TXN_INST;
    pv = PRIVILEGE_OVERRIDE[1] ? PRIVILEGE_OVERRIDE[0] : TXN_PRIV;
    ok = k == 1 || (k != 3 && !S2_FAULT && (k == 0 || (TXN_WRITE ? S2_PERM[1]
      : iv ? S2_PERM[(pv && SPLIT_EXEC_PERM_CAPABILITY) ? 3 : 2] : S2_PERM[0])));
    sp = ATS_MODE_FIELD == ATA_MODE_SPLIT;
    ew = !S2_FAULT && S1_PERM[1] && S2_PERM[1];
    @(posedge CLK);
    #1;
    if (TXN_VALID) begin
      chk({OUT_VALID, EVT_VALID, CPL_VALID, TREQ_READY}, {ok, !ok, 2'h0});
      if (ok) chk({OUT_WRITE, OUT_ADDR[51:0], OUT_MT, OUT_SH},
        {TXN_WRITE, (k == 1) ? TXN_ADDR[51:0] : S2_OUT_ADDR[51:0], nsd(ea)});
      else chk(EVT_CODE, (k == 3) ? ATA_EVT_ATS_BLOCK : S2_FAULT ? ATA_EVT_S2_FAULT : ATA_EVT_S2_PERM);
      if (ok && k > 1) chk({OUT_INST, OUT_PRIV, HTTU_DIRTY}, {iv, pv, TXN_WRITE && !HTTU_AT_REQUEST});
    end else if (TREQ_VALID) begin
      chk({TREQ_READY, CPL_VALID, CPL_N, CPL_R, CPL_X, CPL_W && !ew}, {3'h6, !S2_FAULT && S1_PERM[0] && S2_PERM[0],
        TREQ_EXEC && !S2_FAULT && S1_PERM[2] && S2_PERM[2], 1'b0});
      if (!TREQ_NO_WRITE) chk({CPL_W, HTTU_DIRTY}, {ew, sp && HTTU_AT_REQUEST && ew});
      chk(CPL_SIZE, (S1_SIZE < S2_SIZE) ? S1_SIZE : S2_SIZE);
      if (!S2_FAULT) chk(CPL_ADDR[51:0], sp ? S1_OUT_ADDR[51:0] : S2_OUT_ADDR[51:0]);
      if (sp && ATS_ATTR_SUPPORT && !STAGE2_FORCED_WRITEBACK)
        chk(comb({CPL_ADDR[59:52], CPL_ADDR[61:60]}, s2), comb({S1_MT, S1_SH}, s2));
    end else chk({OUT_VALID, EVT_VALID, CPL_VALID}, 3'h0);
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
  initial begin
    {RESETN, NO_SNOOP_SUPPORT, ATS_ATTR_SUPPORT, TRANSLATED_CHECK_ENABLE, SPLIT_EXEC_PERM_CAPABILITY, HTTU_AT_REQUEST,
      MEMTYPE_OVERRIDE_EN, SHAREABILITY_OVERRIDE_EN, STAGE2_FORCED_WRITEBACK, TXN_VALID, TXN_TRANSLATED, TXN_WRITE,
      TXN_INST, TXN_PRIV, TXN_NO_SNOOP, TREQ_VALID, TREQ_NO_WRITE, TREQ_EXEC, TREQ_PRIV, S2_FAULT, ATS_MODE_FIELD,
      INSTRUCTION_OVERRIDE, PRIVILEGE_OVERRIDE, SHAREABILITY_OVERRIDE, S1_SH, S2_SH, STAGE_CONFIG, S1_PERM, S2_PERM,
      S1_SIZE, S2_SIZE, MEMTYPE_OVERRIDE, S1_MT, S2_MT, TXN_ADDR, S1_OUT_ADDR, S2_OUT_ADDR} = '0;
    seed = 32'h63;
    err_count = 0;
    checks_done = 0;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    RESETN = 1'b1;
    chk({OUT_VALID, EVT_VALID, CPL_VALID, CPL_N, EVT_CODE}, 6'h00);
    op(4);
    op(2);
    op(0);
    op(6);
    op(3);
    op(5);
    repeat (300) op(int'(rnd() % 7));
    wrap_up();
  end
endmodule
